/* File: design/cfs_flags_stack.sv */
// Purpose: condition flags, interrupt priority bits and stack pointer of the core
// Assumes: the sequencer presents one operation per cycle and waits for ctx_busy_out
// Notes: stack memory itself lives outside; this block emits address, data and strobes
// Notes: a context move takes five cycles and refuses other commands meanwhile
//
// Behaviour
// - add and add-with-carry set half carry on bit 3 to 4 carry, else clear.
// - every result-producing instruction copies result bit 7 into the sign flag.
// - every result-producing instruction sets zero flag iff result is zero.
// - carry follows arithmetic, set/clear-carry, bit-test-branch, shift and rotate.
// - conditional jumps test each flag set or clear in pairs.
// - priority bits 5 and 3 encode levels 10,01,00,11 for levels 0..3.
// - interrupt entry loads priority bits from the source priority registers.
// - enable, disable, return, halt, wait and pop also write priority bits.
// - flags register 8 bits, pushable, resets with top three bits and bit 3 set.
// - pointer addresses next free byte; decrement after push, increment before pop.
// - 128-byte stack, upper pointer byte forced constant, reset value 017Fh.
// - reset and the stack reinit instruction both restore pointer to 017Fh.
// - pointer wraps silently at both stack limits, no overflow indication.
// - low pointer byte loadable and readable, upper byte unaffected.
// - interrupt stores program counter low first at the addressed location.
// - call uses two stack bytes, interrupt five, interrupt return pops five.
// - second index register is not part of the interrupt context.
module cfs_flags_stack
    import cfs_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // alu result and flag update
    input wire logic [3:0] flag_op_in,
    input wire logic [7:0] result_in,
    input wire logic half_carry_in,
    input wire logic carry_in,
    input wire logic [1:0] prio_wr_in,
    input wire logic [7:0] flags_wr_in,
    // conditional jump query
    input wire logic [2:0] jump_sel_in,
    // stack pointer commands from the sequencer
    input wire logic push_in,
    input wire logic pop_in,
    input wire logic stack_reinit_instr_in,
    input wire logic sp_load_in,
    input wire logic [7:0] sp_load_data_in,
    // interrupt context entry and return
    input wire logic irq_enter_in,
    input wire logic irq_return_instr_in,
    input wire logic [1:0] source_priority_registers_in,
    input wire logic [15:0] pc_in,
    input wire logic [7:0] index_in,
    input wire logic [7:0] acc_in,
    input wire logic [7:0] stack_rd_data_in,
    // register views
    output logic [7:0] condition_flags_out,
    output logic [15:0] stack_top_pointer_out,
    output logic jump_taken_out,
    // stack memory access for context moves
    output logic ctx_busy_out,
    output logic stack_wr_out,
    output logic stack_rd_out,
    output logic [15:0] stack_addr_out,
    output logic [7:0] stack_wr_data_out,
    // restored context, valid on ctx_restore_out pulses
    output logic ctx_restore_out,
    output logic [2:0] ctx_restore_sel_out,
    output logic [7:0] ctx_restore_data_out
);

    // state registers and their next values
    logic [7:0] flags_ff;
    logic [7:0] nxt_flags;
    logic [7:0] sp_low_ff;
    logic [7:0] nxt_sp_low;
    cfs_ctx_e ctx_ff;
    cfs_ctx_e nxt_ctx;
    logic ctx_dir_ff;            // 1 = pushing context, 0 = popping
    logic [1:0] irq_prio_ff;     // priority to load once the save completes
    logic ctx_step;
    logic ctx_push_step;
    logic ctx_pop_step;
    logic do_push;
    logic do_pop;
    logic [7:0] sp_dec;
    logic [7:0] sp_inc;
    logic jump_hit;
    // strobes of the coming cycle, decoded from the next sequencer state
    logic ctx_wr_next;
    logic ctx_rd_next;
    // pointer plus one after this cycle's update, where the next pop reads
    logic [7:0] nxt_sp_up;

    // wrap inside the 00h..7Fh window of the stack page
    assign sp_dec = (sp_low_ff == SP_LOW_BOTTOM) ? SP_LOW_TOP : sp_low_ff - 8'h01;
    assign sp_inc = (sp_low_ff == SP_LOW_TOP) ? SP_LOW_BOTTOM : sp_low_ff + 8'h01;

    assign ctx_step = (ctx_ff != CTX_IDLE);
    assign ctx_push_step = ctx_step && ctx_dir_ff;
    assign ctx_pop_step = ctx_step && !ctx_dir_ff;
    assign do_push = ctx_push_step || (!ctx_step && push_in);
    assign do_pop = ctx_pop_step || (!ctx_step && pop_in);

    // the strobe must leave with the byte it qualifies, so both come from the
    // next state; taken from the present state each write would land one
    // byte late and the program counter low byte would never be stored
    assign ctx_wr_next = (nxt_ctx != CTX_IDLE)
                         && ((ctx_ff == CTX_IDLE) ? irq_enter_in : ctx_dir_ff);
    assign ctx_rd_next = (nxt_ctx != CTX_IDLE) && !ctx_wr_next;

    // increment before pop: the read for the coming step goes one above the
    // pointer that this cycle leaves behind
    assign nxt_sp_up = (nxt_sp_low == SP_LOW_TOP) ? SP_LOW_BOTTOM : nxt_sp_low + 8'h01;

    // context move timing, one byte per cycle:
    //  entry edge  - busy rises, pcl write presented at the current pointer
    //  next four   - pch, index, accumulator, flags at falling addresses
    //  last edge   - priority bits take the captured level, pointer five down
    //  return edge - first read presented one above the pointer
    //  next five   - flags, accumulator, index, pch, pcl come back in turn
    // memory answers combinationally while the read strobe stands, so each
    // pop step consumes the byte whose read was launched on the edge before
    // limitation: pc, index and accumulator must hold still through the save
    // context sequencer: five bytes each way, second index register excluded
    always_comb begin
        nxt_ctx = ctx_ff;
        case (ctx_ff)
            CTX_IDLE: begin
                if (irq_enter_in) begin
                    nxt_ctx = CTX_PCL;
                end else if (irq_return_instr_in) begin
                    nxt_ctx = CTX_FLG;
                end
            end
            CTX_PCL: nxt_ctx = ctx_dir_ff ? CTX_PCH : CTX_IDLE;
            CTX_PCH: nxt_ctx = ctx_dir_ff ? CTX_IDX : CTX_PCL;
            CTX_IDX: nxt_ctx = ctx_dir_ff ? CTX_ACC : CTX_PCH;
            CTX_ACC: nxt_ctx = ctx_dir_ff ? CTX_FLG : CTX_IDX;
            CTX_FLG: nxt_ctx = ctx_dir_ff ? CTX_IDLE : CTX_ACC;
            default: nxt_ctx = CTX_IDLE;
        endcase
    end

    // sequencer state and direction
    // direction and captured level change only when a move starts, so a
    // stray request in mid-move cannot alter the frame
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctx_ff <= CTX_IDLE;
            ctx_dir_ff <= 1'b1;
            irq_prio_ff <= PRIO_LVL3;
        end else begin
            ctx_ff <= nxt_ctx;
            if (ctx_ff == CTX_IDLE && irq_enter_in) begin
                ctx_dir_ff <= 1'b1;
                irq_prio_ff <= source_priority_registers_in;
            end else if (ctx_ff == CTX_IDLE && irq_return_instr_in) begin
                ctx_dir_ff <= 1'b0;
            end
        end
    end

    // stack pointer low byte; high byte is a constant
    // commands are refused while a context move runs, since the mover owns
    // the pointer then; a push in that window would corrupt the frame
    // priority among commands: reinit, then load, then push, then pop
    always_comb begin
        nxt_sp_low = sp_low_ff;
        if (stack_reinit_instr_in && !ctx_step) begin
            nxt_sp_low = SP_LOW_TOP;
        end else if (sp_load_in && !ctx_step) begin
            // low byte load, wrapped to stack window
            nxt_sp_low = {1'b0, sp_load_data_in[6:0]};
        end else if (do_push) begin
            nxt_sp_low = sp_dec;
        end else if (do_pop) begin
            nxt_sp_low = sp_inc;
        end
    end

    // reset to stack top
    // only the low byte is stored; the page byte is wired in at the view
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sp_low_ff <= SP_LOW_TOP;
        end else begin
            sp_low_ff <= nxt_sp_low;
        end
    end

    // a restore writes the whole byte, so priority and result flags return
    // together; the save stores the flags before the new level applies
    // flag update; untouched bits hold by default
    always_comb begin
        nxt_flags = flags_ff;
        if (ctx_pop_step && ctx_ff == CTX_FLG) begin
            nxt_flags = stack_rd_data_in;
        end else if (ctx_push_step && ctx_ff == CTX_FLG) begin
            // load priority after flags were saved
            nxt_flags[CF_PH_BIT] = irq_prio_ff[1];
            nxt_flags[CF_PL_BIT] = irq_prio_ff[0];
        end else if (!ctx_step) begin
            case (flag_op_in)
                CFS_OP_ADD: begin
                    nxt_flags[CF_H_BIT] = half_carry_in;
                    nxt_flags[CF_N_BIT] = result_in[7];
                    nxt_flags[CF_Z_BIT] = (result_in == 8'h00);
                    nxt_flags[CF_C_BIT] = carry_in;
                end
                CFS_OP_SUB, CFS_OP_SHIFT: begin
                    nxt_flags[CF_N_BIT] = result_in[7];
                    nxt_flags[CF_Z_BIT] = (result_in == 8'h00);
                    nxt_flags[CF_C_BIT] = carry_in;
                end
                CFS_OP_LOGIC: begin
                    nxt_flags[CF_N_BIT] = result_in[7];
                    nxt_flags[CF_Z_BIT] = (result_in == 8'h00);
                end
                CFS_OP_BTJ: nxt_flags[CF_C_BIT] = carry_in;
                CFS_OP_SCF: nxt_flags[CF_C_BIT] = 1'b1;
                CFS_OP_RCF: nxt_flags[CF_C_BIT] = 1'b0;
                // enable = level 0, disable = level 3
                CFS_OP_RIM: begin
                    nxt_flags[CF_PH_BIT] = PRIO_LVL0[1];
                    nxt_flags[CF_PL_BIT] = PRIO_LVL0[0];
                end
                CFS_OP_SIM: begin
                    nxt_flags[CF_PH_BIT] = PRIO_LVL3[1];
                    nxt_flags[CF_PL_BIT] = PRIO_LVL3[0];
                end
                CFS_OP_PRIO: begin
                    nxt_flags[CF_PH_BIT] = prio_wr_in[1];
                    nxt_flags[CF_PL_BIT] = prio_wr_in[0];
                end
                CFS_OP_LOAD: nxt_flags = flags_wr_in;
                default: nxt_flags = flags_ff;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            flags_ff <= CF_RESET;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    // jump condition, decided from current flags
    // answered one cycle later, so it reflects the op issued before the query
    always_comb begin
        case (cfs_jump_e'(jump_sel_in))
            CFS_JH: jump_hit = flags_ff[CF_H_BIT];
            CFS_JNH: jump_hit = !flags_ff[CF_H_BIT];
            CFS_JMI: jump_hit = flags_ff[CF_N_BIT];
            CFS_JPL: jump_hit = !flags_ff[CF_N_BIT];
            CFS_JEQ: jump_hit = flags_ff[CF_Z_BIT];
            CFS_JNE: jump_hit = !flags_ff[CF_Z_BIT];
            CFS_JC: jump_hit = flags_ff[CF_C_BIT];
            CFS_JNC: jump_hit = !flags_ff[CF_C_BIT];
            default: jump_hit = 1'b0;
        endcase
    end

    // registered views of flags, pointer and jump decision
    // flag and pointer views take the next value, so they move on the same edge as the state
    // and the sequencer never sees a flag one cycle stale
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            condition_flags_out <= CF_RESET;
            stack_top_pointer_out <= SP_RESET;
            jump_taken_out <= 1'b0;
            ctx_busy_out <= 1'b0;
        end else begin
            condition_flags_out <= nxt_flags;
            stack_top_pointer_out <= {SP_HIGH_BYTE, nxt_sp_low};
            jump_taken_out <= jump_hit;
            ctx_busy_out <= (nxt_ctx != CTX_IDLE);
        end
    end

    // stack memory strobes; a pop reads at the incremented address
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            stack_wr_out <= 1'b0;
            stack_rd_out <= 1'b0;
            stack_addr_out <= SP_RESET;
            stack_wr_data_out <= 8'h00;
        end else begin
            // a write and a read never stand together: direction is fixed per move
            stack_wr_out <= ctx_wr_next;
            stack_rd_out <= ctx_rd_next;
            // pcl at addressed location
            // writes go where the pointer points, reads one above it
            stack_addr_out <= {SP_HIGH_BYTE, ctx_rd_next ? nxt_sp_up : nxt_sp_low};
            case (nxt_ctx)
                CTX_PCL: stack_wr_data_out <= pc_in[7:0];
                CTX_PCH: stack_wr_data_out <= pc_in[15:8];
                CTX_IDX: stack_wr_data_out <= index_in;
                CTX_ACC: stack_wr_data_out <= acc_in;
                CTX_FLG: stack_wr_data_out <= nxt_flags;
                default: stack_wr_data_out <= 8'h00;
            endcase
        end
    end

    // restored context bytes handed back to the sequencer
    // the select names the register to refill, from the state that consumed it
    always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            ctx_restore_out <= 1'b0;
            ctx_restore_sel_out <= 3'h0;
            ctx_restore_data_out <= 8'h00;
        end else begin
            ctx_restore_out <= ctx_pop_step;
            ctx_restore_data_out <= stack_rd_data_in;
            case (ctx_ff)
                CTX_FLG: ctx_restore_sel_out <= 3'h4;
                CTX_ACC: ctx_restore_sel_out <= 3'h3;
                CTX_IDX: ctx_restore_sel_out <= 3'h2;
                CTX_PCH: ctx_restore_sel_out <= 3'h1;
                default: ctx_restore_sel_out <= 3'h0;
            endcase
        end
    end

endmodule // cfs_flags_stack

/* File: design/cfs_pkg.sv */
// Purpose: shared constants for the condition flags and stack pointer block
// Assumes: 8-bit core, 128-byte stack in page 01h
// Notes: operation codes are presented by the instruction sequencer
package cfs_pkg;
    // flag bit positions inside condition_flags
    localparam int unsigned CF_C_BIT = 0;
    localparam int unsigned CF_Z_BIT = 1;
    localparam int unsigned CF_N_BIT = 2;
    localparam int unsigned CF_PL_BIT = 3;
    localparam int unsigned CF_H_BIT = 4;
    localparam int unsigned CF_PH_BIT = 5;
    // reset value; undefined bits are taken as one
    localparam logic [7:0] CF_RESET = 8'hE8;
    // priority encodings {high,low}
    localparam logic [1:0] PRIO_LVL0 = 2'h2;
    localparam logic [1:0] PRIO_LVL1 = 2'h1;
    localparam logic [1:0] PRIO_LVL2 = 2'h0;
    localparam logic [1:0] PRIO_LVL3 = 2'h3;
    // stack pointer
    localparam logic [7:0] SP_HIGH_BYTE = 8'h01;
    localparam logic [7:0] SP_LOW_TOP = 8'h7F;
    localparam logic [7:0] SP_LOW_BOTTOM = 8'h00;
    localparam logic [15:0] SP_RESET = 16'h017F;
    // stack usage per event
    localparam logic [2:0] CALL_BYTES = 3'h2;
    localparam logic [2:0] IRQ_BYTES = 3'h5;
    // flag-update operation classes
    typedef enum logic [3:0] {
        CFS_OP_NONE = 4'h0,
        CFS_OP_ADD = 4'h1,    // add / add-with-carry: h,n,z,c
        CFS_OP_SUB = 4'h2,    // arithmetic without half carry: n,z,c
        CFS_OP_LOGIC = 4'h3,  // logical / data move: n,z
        CFS_OP_SHIFT = 4'h4,  // shift / rotate: n,z,c
        CFS_OP_BTJ = 4'h5,    // bit test and branch: c only
        CFS_OP_SCF = 4'h6,
        CFS_OP_RCF = 4'h7,
        CFS_OP_RIM = 4'h8,
        CFS_OP_SIM = 4'h9,
        CFS_OP_PRIO = 4'hA,   // halt / wfi write priority bits
        CFS_OP_LOAD = 4'hB    // whole-register write (pop)
    } cfs_op_e;
    // conditional jump selectors
    typedef enum logic [2:0] {
        CFS_JH = 3'h0,
        CFS_JNH = 3'h1,
        CFS_JMI = 3'h2,
        CFS_JPL = 3'h3,
        CFS_JEQ = 3'h4,
        CFS_JNE = 3'h5,
        CFS_JC = 3'h6,
        CFS_JNC = 3'h7
    } cfs_jump_e;
    // interrupt context sequencer states, one-hot
    typedef enum logic [5:0] {
        CTX_IDLE = 6'h01,
        CTX_PCL = 6'h02,
        CTX_PCH = 6'h04,
        CTX_IDX = 6'h08,
        CTX_ACC = 6'h10,
        CTX_FLG = 6'h20
    } cfs_ctx_e;
endpackage : cfs_pkg

/* File: verification/cfs_flags_stack_properties.sv */
// Purpose: port assertions for cfs_flags_stack
// Assumes: one command per cycle from the sequencer
// Notes: commands during a context move are not judged
module cfs_flags_stack_properties
    import cfs_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic reset_n_in,
    // commands
    input wire logic [3:0] flag_op_in,
    input wire logic [7:0] result_in,
    input wire logic half_carry_in,
    input wire logic carry_in,
    input wire logic [2:0] jump_sel_in,
    input wire logic push_in,
    input wire logic pop_in,
    input wire logic stack_reinit_instr_in,
    input wire logic sp_load_in,
    input wire logic irq_enter_in,
    input wire logic [15:0] pc_in,
    // observed state
    input wire logic [7:0] condition_flags_out,
    input wire logic [15:0] stack_top_pointer_out,
    input wire logic jump_taken_out,
    input wire logic ctx_busy_out,
    input wire logic stack_wr_out,
    input wire logic [15:0] stack_addr_out,
    input wire logic [7:0] stack_wr_data_out
);
    // short views; a busy sequence refuses commands
    wire logic [7:0] cf = condition_flags_out;
    wire logic [6:0] lo = stack_top_pointer_out[6:0];
    wire logic quiet = !ctx_busy_out;
    wire logic sp_idle = quiet && !stack_reinit_instr_in && !sp_load_in;

    // flag picked by a jump selector, odd codes invert
    function automatic logic jt(logic [7:0] f, logic [2:0] s);
        logic [3:0] v;
        v = {f[0], f[1], f[2], f[4]};
        return s[0] ^ v[s[2:1]];
    endfunction

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    a_reset_start: assert property (
        $rose(reset_n_in) |-> cf == CF_RESET && stack_top_pointer_out == SP_RESET)
        else $error("reset values wrong");
    a_add_flags: assert property (
        quiet && flag_op_in == CFS_OP_ADD |=> cf[4] == $past(half_carry_in)
        && cf[2:0] == {$past(result_in[7]), $past(result_in) == 8'h00, $past(carry_in)})
        else $error("add flags wrong");
    a_logic_keeps: assert property (
        quiet && flag_op_in == CFS_OP_LOGIC |=> $stable(cf[5:3]) && $stable(cf[0])
        && cf[2] == $past(result_in[7]))
        else $error("logic op disturbed flags");
    a_carry_set: assert property (
        quiet && flag_op_in == CFS_OP_SCF |=> cf[0] && $stable(cf[5:1]))
        else $error("set carry wrong");
    a_prio_enable: assert property (
        quiet && flag_op_in == CFS_OP_RIM |=> {cf[5], cf[3]} == PRIO_LVL0)
        else $error("enable level wrong");
    a_jump_pair: assert property (
        quiet && flag_op_in == CFS_OP_NONE |=> jump_taken_out == jt(cf, $past(jump_sel_in)))
        else $error("jump decision wrong");
    a_sp_push: assert property (
        sp_idle && push_in |=> lo == $past(lo) - 7'h01)
        else $error("push pointer wrong");
    a_sp_pop: assert property (
        sp_idle && pop_in && !push_in |=> lo == $past(lo) + 7'h01)
        else $error("pop pointer wrong");
    a_sp_reinit: assert property (
        quiet && stack_reinit_instr_in |=> stack_top_pointer_out == SP_RESET)
        else $error("reinit pointer wrong");
    a_sp_high: assert property (
        stack_top_pointer_out[15:7] == {SP_HIGH_BYTE, 1'b0})
        else $error("pointer page wrong");
    a_ctx_save: assert property (
        quiet && irq_enter_in |=> stack_wr_out && stack_addr_out == $past(stack_top_pointer_out)
        && stack_wr_data_out == $past(pc_in[7:0]) ##1 stack_wr_out [*4] ##1 !stack_wr_out)
        else $error("context save wrong");
endmodule // cfs_flags_stack_properties

bind cfs_flags_stack cfs_flags_stack_properties u_props (.*);

/* File: verification/cfs_stack_mem.sv */
// Purpose: stack ram seen by the context mover
// Assumes: read data is used only while the read strobe stands
// Notes: outside that cycle the data lines carry a moving pattern
module cfs_stack_mem (
    // clock
    input wire logic clk_in,
    // strobes and address
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [15:0] addr_in,
    input wire logic [7:0] wdata_in,
    // read data
    output logic [7:0] rdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [128];
    logic [7:0] junk = 8'h3C;
    // store pushed bytes; the filler pattern moves every cycle
    always_ff @(posedge clk_in) begin
        if (wr_in) begin
            mem[addr_in[6:0]] <= wdata_in;
        end
        junk <= junk + 8'h5B;
    end
    // combinational read while the strobe stands; stale data would hide a
    // misplaced read, so a moving pattern shows at all other times
    assign rdata_out = rd_in ? mem[addr_in[6:0]] : junk;
endmodule // cfs_stack_mem

/* File: verification/cfs_flags_stack_test.sv */
// Purpose: self-checking bench for cfs_flags_stack
// Assumes: stack memory model answers context reads
// Notes: random stimulus from a fixed-seed lfsr
module cfs_flags_stack_test
    import cfs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_in, reset_n_in, half_carry_in, carry_in, push_in, pop_in;
    logic stack_reinit_instr_in, sp_load_in, irq_enter_in, irq_return_instr_in;
    logic [3:0] flag_op_in;
    logic [7:0] result_in, flags_wr_in, sp_load_data_in, index_in, acc_in;
    logic [1:0] prio_wr_in, source_priority_registers_in;
    logic [2:0] jump_sel_in;
    logic [15:0] pc_in;
    wire logic [7:0] stack_rd_data_in, condition_flags_out, stack_wr_data_out;
    wire logic [7:0] ctx_restore_data_out;
    wire logic [15:0] stack_top_pointer_out, stack_addr_out;
    wire logic jump_taken_out, ctx_busy_out, stack_wr_out, stack_rd_out, ctx_restore_out;
    wire logic [2:0] ctx_restore_sel_out;
    int num_errors = 0;
    int n_checks = 0;
    logic [31:0] seed = 32'h9ECD8D56;
    logic [7:0] ef;
    logic [6:0] es;

    cfs_flags_stack u_dut (.*);
    cfs_stack_mem u_mem (
        .clk_in(ref_clk_in),
        .wr_in(stack_wr_out),
        .rd_in(stack_rd_out),
        .addr_in(stack_addr_out),
        .wdata_in(stack_wr_data_out),
        .rdata_out(stack_rd_data_in)
    );

    function automatic logic [31:0] lfsr(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // expected flags after one operation class
    function automatic logic [7:0] nf(logic [7:0] f, logic [3:0] o, logic [7:0] r,
        logic h, logic c, logic [1:0] p, logic [7:0] w);
        nf = f;
        if (o inside {4'h1, 4'h2, 4'h3, 4'h4}) nf[2:1] = {r[7], r == 8'h00};
        if (o == 4'h1) nf[4] = h;
        if (o inside {4'h1, 4'h2, 4'h4, 4'h5}) nf[0] = c;
        if (o == 4'h6 || o == 4'h7) nf[0] = o == 4'h6;
        if (o == 4'h8) {nf[5], nf[3]} = PRIO_LVL0;
        if (o == 4'h9) {nf[5], nf[3]} = PRIO_LVL3;
        if (o == 4'hA) {nf[5], nf[3]} = p;
        if (o == 4'hB) nf = w;
    endfunction

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report;
        if (num_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // one flag operation, then a jump query on the following cycle
    task automatic alu(input logic [3:0] op);
        seed = lfsr(seed);
        flag_op_in <= op;
        result_in <= seed[7:0];
        half_carry_in <= seed[8];
        carry_in <= seed[9];
        prio_wr_in <= seed[11:10];
        flags_wr_in <= {2'b11, seed[17:12]};
        ef = nf(ef, op, seed[7:0], seed[8], seed[9], seed[11:10], {2'b11, seed[17:12]});
        @(posedge ref_clk_in);
        flag_op_in <= CFS_OP_NONE;
        jump_sel_in <= seed[20:18];
        #1;
        chk(condition_flags_out, ef); // flags
        @(posedge ref_clk_in);
    endtask

    // one pointer command: 0 push, 1 pop, 2 reinit, 3 load
    task automatic stk(input int k, input logic [7:0] d);
        push_in <= k == 0;
        pop_in <= k == 1;
        stack_reinit_instr_in <= k == 2;
        sp_load_in <= k == 3;
        sp_load_data_in <= d;
        es = k == 0 ? es - 7'h01 : k == 1 ? es + 7'h01 : k == 2 ? 7'h7F : d[6:0];
        @(posedge ref_clk_in);
        {push_in, pop_in, stack_reinit_instr_in, sp_load_in} <= 4'h0;
        #1;
        chk(stack_top_pointer_out, {9'h002, es}); // pointer
        @(posedge ref_clk_in);
    endtask

    // save a context at pointer low s0, then bring it back
    task automatic irq(input logic [6:0] s0);
        logic [7:0] sv [5];
        int n;
        stk(3, {1'b0, s0});
        seed = lfsr(seed);
        sv = '{seed[7:0], seed[15:8], seed[23:16], seed[31:24], ef};
        pc_in <= seed[15:0];
        index_in <= seed[23:16];
        acc_in <= seed[31:24];
        source_priority_registers_in <= seed[5:4];
        irq_enter_in <= 1'b1;
        @(posedge ref_clk_in);
        irq_enter_in <= 1'b0;
        #1;
        n = 0;
        while (ctx_busy_out === 1'b1 && n < 12) begin
            @(posedge ref_clk_in);
            #1;
            n++;
        end
        chk(ctx_busy_out, 1'b0);
        for (int i = 0; i < 5; i++) chk(u_mem.mem[s0 - 7'(i)], sv[i]); // order
        es = s0 - 7'h05;
        {ef[5], ef[3]} = seed[5:4];
        chk(stack_top_pointer_out, {9'h002, es}); // five bytes
        chk(condition_flags_out, ef); // level loaded
        @(posedge ref_clk_in);
        irq_return_instr_in <= 1'b1;
        @(posedge ref_clk_in);
        irq_return_instr_in <= 1'b0;
        n = 0;
        repeat (20) begin
            #1;
            if (ctx_restore_out === 1'b1) begin
                chk(ctx_restore_data_out, sv[ctx_restore_sel_out]); // restored
                n++;
            end
            @(posedge ref_clk_in);
        end
        #1;
        es = s0;
        ef = sv[4];
        chk(16'(n), 16'h0005); // five pops
        chk(stack_top_pointer_out, {9'h002, es}); // pointer back
        chk(condition_flags_out, ef); // flags back
        @(posedge ref_clk_in);
    endtask

    // 125 MHz clock
    initial begin
        ref_clk_in = 1'b0;
        forever #4 ref_clk_in = ~ref_clk_in;
    end

    // hang guard, far above the expected run
    initial begin
        repeat (8000) @(posedge ref_clk_in);
        num_errors++;
        final_report();
    end

    // main sequence: reset, flags, pointer, context moves
    initial begin
        {flag_op_in, result_in, half_carry_in, carry_in, prio_wr_in, flags_wr_in} = '0;
        {jump_sel_in, push_in, pop_in, stack_reinit_instr_in, sp_load_in} = '0;
        {sp_load_data_in, irq_enter_in, irq_return_instr_in} = '0;
        {source_priority_registers_in, pc_in, index_in, acc_in} = '0;
        reset_n_in = 1'b0;
        ef = CF_RESET;
        es = 7'h7F;
        repeat (8) @(posedge ref_clk_in);
        reset_n_in <= 1'b1;
        @(posedge ref_clk_in);
        #1;
        chk(condition_flags_out, CF_RESET); // flags start
        chk(stack_top_pointer_out, SP_RESET); // pointer start
        @(posedge ref_clk_in);
        for (int i = 1; i < 12; i++) alu(4'(i)); // every class
        repeat (80) begin
            seed = lfsr(seed);
            alu(4'(seed[3:0] % 4'hC));
        end
        repeat (130) stk(0, 8'h00);
        repeat (131) stk(1, 8'h00);
        repeat (60) begin
            seed = lfsr(seed);
            stk(int'(seed[1:0]), seed[15:8]);
        end
        irq(7'h02);
        irq(7'h40);
        final_report();
    end
endmodule // cfs_flags_stack_test
